// File: hw/cilp_pkg.sv
package cilp_pkg;
  // ------------------------------------------------------------
  // register word offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] CILP_MODULE_CONTROL_0 = 8'h00;
  localparam logic [7:0] CILP_MODULE_CONTROL_1 = 8'h04;
  localparam logic [7:0] CILP_BUS_TIMING_0 = 8'h08;
  localparam logic [7:0] CILP_BUS_TIMING_1 = 8'h0C;
  localparam logic [7:0] CILP_RX_FLAG_REGISTER = 8'h10;
  localparam logic [7:0] CILP_RX_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] CILP_TX_FLAG_REGISTER = 8'h18;
  localparam logic [7:0] CILP_TX_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] CILP_ACCEPTANCE_CONTROL = 8'h20;
  localparam logic [7:0] CILP_ERROR_COUNTERS = 8'h24;
  localparam logic [7:0] CILP_ACCEPTANCE_PATTERNS = 8'h30;
  localparam logic [7:0] CILP_ACCEPTANCE_MASKS = 8'h40;
  localparam logic [7:0] CILP_STATUS = 8'h50;
  localparam logic [7:0] CILP_FILTER_SPAN = 8'h10;

  // ------------------------------------------------------------
  // module_control_0 fields and module control 1 wakeup filter bit
  // ------------------------------------------------------------
  localparam int CILP_MC0_SOFT_RESET = 0;
  localparam int CILP_MC0_SLEEP_ACK = 1;
  localparam int CILP_MC0_SLEEP_REQ = 2;
  localparam int CILP_MC0_TIMER_LINK = 3;
  localparam logic [7:0] CILP_MC0_RESET = 8'h01;
  localparam int CILP_MC1_WAKEUP_FILTER = 2;

  // rx flag register bits (flags and enables share positions)
  localparam int CILP_RF_RX_FULL = 0;
  localparam int CILP_RF_OVERRUN = 1;
  localparam int CILP_RF_BUS_OFF = 2;
  localparam int CILP_RF_TX_PASSIVE = 3;
  localparam int CILP_RF_RX_PASSIVE = 4;
  localparam int CILP_RF_TX_WARNING = 5;
  localparam int CILP_RF_RX_WARNING = 6;
  localparam int CILP_RF_WAKEUP = 7;
  localparam logic [7:0] CILP_RF_ERR_MASK = 8'h7E;
  localparam logic [2:0] CILP_TX_EMPTY_RESET = 3'h7;

  // ------------------------------------------------------------
  // error limits and timing
  // ------------------------------------------------------------
  localparam logic [8:0] CILP_WARN_LIMIT = 9'h060;
  localparam logic [8:0] CILP_PASSIVE_LIMIT = 9'h07F;
  localparam logic [8:0] CILP_BUS_OFF_LIMIT = 9'h0FF;
  localparam int CILP_IDLE_BITS = 11;
  localparam int CILP_RECOVERY_RUNS = 128;
  localparam int CILP_WAKE_FILTER_CYCLES = 4;

  typedef enum logic [1:0] {
    CILP_MODE_NORMAL,
    CILP_MODE_SLEEP,
    CILP_MODE_SOFT_RESET,
    CILP_MODE_POWER_DOWN
  } cilp_mode_e;
endpackage

// File: hw/cilp_can_irq_lowpower.sv
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cilp_can_irq_lowpower #(
  parameter int FILTER_REGS = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // cpu and protocol engine
  input wire logic cpu_stop_i,
  input wire logic engine_tx_bit_i,
  input wire logic engine_tx_busy_i,
  input wire logic engine_rx_busy_i,
  input wire logic engine_eof_ok_i,
  input wire logic engine_rx_stored_i,
  input wire logic engine_overrun_i,
  input wire logic engine_tx_done_i,
  input wire logic [2:0] engine_tx_done_buf_i,
  input wire logic engine_bit_tick_i,
  input wire logic [8:0] rx_err_count_i,
  input wire logic [8:0] tx_err_count_i,
  input wire logic can_receive_pin_i,
  // outputs
  output logic can_transmit_pin_o,
  output logic engine_run_o,
  output logic engine_copy_en_o,
  output logic engine_abort_en_o,
  output logic engine_stop_o,
  output logic recovery_done_o,
  output logic [2:0] tx_scheduled_o,
  output logic wakeup_irq_o,
  output logic error_irq_o,
  output logic rx_irq_o,
  output logic tx_irq_o,
  output logic timer_capture_o,
  output logic cpu_wake_o
);
  import cilp_pkg::*;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] ctrl0_ff, ctrl1_ff, btr0_ff, btr1_ff, idac_ff;
  logic [7:0] pattern_ff [FILTER_REGS];
  logic [7:0] mask_ff [FILTER_REGS];
  logic [7:0] rx_flag_ff, rx_en_ff;
  logic [2:0] tx_empty_ff, tx_en_ff;
  logic rx_meta_ff, rx_sync_ff, rx_prev_ff;
  logic [3:0] idle_cnt_ff;
  logic [7:0] recov_runs_ff;
  logic [3:0] recov_bits_ff;
  logic resync_ff;
  logic [7:0] wake_filt_ff;
  logic pulse_ff;
  cilp_mode_e mode_ff;

  logic bus_wr, bus_rd, cfg_unlocked, in_sleep, bus_off_now, low_power, activity;
  logic [7:0] wbyte;
  assign wbyte = dat_i[7:0];
  // power down refuses all access; single cycle answer
  assign bus_wr = cyc_i && stb_i && we_i && sel_i[0] && !ack_o && !cpu_stop_i;
  assign bus_rd = cyc_i && stb_i && !we_i && !ack_o && !cpu_stop_i;
  assign cfg_unlocked = ctrl0_ff[CILP_MC0_SOFT_RESET];
  assign in_sleep = ctrl0_ff[CILP_MC0_SLEEP_ACK];
  assign bus_off_now = tx_err_count_i > CILP_BUS_OFF_LIMIT;
  assign low_power = mode_ff != CILP_MODE_NORMAL;
  // falling edge on synchronised receive line means a dominant start
  assign activity = rx_prev_ff && !rx_sync_ff;

  // ------------------------------------------------------------
  // receive pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= can_receive_pin_i;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
    end
  end

  // wakeup low-pass: dominant must persist when filter mode set
  logic wake_seen;
  assign wake_seen = ctrl1_ff[CILP_MC1_WAKEUP_FILTER] ?
                     (wake_filt_ff == 8'(CILP_WAKE_FILTER_CYCLES)) : activity;
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_sync_ff) begin
      wake_filt_ff <= 8'h00;
    end else if (wake_filt_ff != 8'(CILP_WAKE_FILTER_CYCLES)) begin
      wake_filt_ff <= wake_filt_ff + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // module control 0: sleep handshake and soft reset
  // ------------------------------------------------------------
  logic sleep_req_wr;
  assign sleep_req_wr = bus_wr && adr_i == CILP_MODULE_CONTROL_0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0_ff <= CILP_MC0_RESET;
    end else begin
      if (sleep_req_wr) begin
        ctrl0_ff[CILP_MC0_SOFT_RESET] <= wbyte[CILP_MC0_SOFT_RESET];
        ctrl0_ff[CILP_MC0_TIMER_LINK] <= wbyte[CILP_MC0_TIMER_LINK];
        // a clear before acknowledge is dropped
        if (wbyte[CILP_MC0_SLEEP_REQ] || in_sleep) begin
          ctrl0_ff[CILP_MC0_SLEEP_REQ] <= wbyte[CILP_MC0_SLEEP_REQ];
        end
      end
      // leave sleep on activity, request cleared, soft reset set
      if (in_sleep && (wake_seen || (sleep_req_wr && !wbyte[CILP_MC0_SLEEP_REQ]) ||
          (sleep_req_wr && wbyte[CILP_MC0_SOFT_RESET]))) begin
        ctrl0_ff[CILP_MC0_SLEEP_ACK] <= 1'b0;
        if (wake_seen) begin
          ctrl0_ff[CILP_MC0_SLEEP_REQ] <= 1'b0;
        end
      end else if (ctrl0_ff[CILP_MC0_SLEEP_REQ] && !cfg_unlocked && !engine_tx_busy_i &&
                   !engine_rx_busy_i && tx_scheduled_o == 3'h0) begin
        ctrl0_ff[CILP_MC0_SLEEP_ACK] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // locked configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1_ff <= 8'h00;
      btr0_ff <= 8'h00;
      btr1_ff <= 8'h00;
      idac_ff <= 8'h00;
    end else if (bus_wr && cfg_unlocked) begin
      unique case (adr_i)
        CILP_MODULE_CONTROL_1: ctrl1_ff <= wbyte;
        CILP_BUS_TIMING_0: btr0_ff <= wbyte;
        CILP_BUS_TIMING_1: btr1_ff <= wbyte;
        CILP_ACCEPTANCE_CONTROL: idac_ff <= wbyte;
        default: ;
      endcase
    end
  end

  // acceptance patterns and masks, one word each
  for (genvar g = 0; g < FILTER_REGS; g++) begin : g_filter
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pattern_ff[g] <= 8'h00;
        mask_ff[g] <= 8'h00;
      end else if (bus_wr && cfg_unlocked) begin
        if (adr_i == CILP_ACCEPTANCE_PATTERNS + 8'(4 * g)) begin
          pattern_ff[g] <= wbyte;
        end
        if (adr_i == CILP_ACCEPTANCE_MASKS + 8'(4 * g)) begin
          mask_ff[g] <= wbyte;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // receiver flags: set wins over write-one clear
  // ------------------------------------------------------------
  logic [7:0] rf_set, rf_clr;
  always_comb begin
    rf_set = 8'h00;
    rf_set[CILP_RF_RX_FULL] = engine_eof_ok_i && engine_rx_stored_i;
    rf_set[CILP_RF_OVERRUN] = engine_overrun_i;
    rf_set[CILP_RF_RX_WARNING] = rx_err_count_i >= CILP_WARN_LIMIT;
    rf_set[CILP_RF_TX_WARNING] = tx_err_count_i >= CILP_WARN_LIMIT;
    rf_set[CILP_RF_RX_PASSIVE] = rx_err_count_i > CILP_PASSIVE_LIMIT;
    rf_set[CILP_RF_TX_PASSIVE] = tx_err_count_i > CILP_PASSIVE_LIMIT;
    rf_set[CILP_RF_BUS_OFF] = bus_off_now;
    rf_set[CILP_RF_WAKEUP] = wake_seen && in_sleep && rx_en_ff[CILP_RF_WAKEUP];
    // zeros in the written byte clear nothing
    rf_clr = (bus_wr && adr_i == CILP_RX_FLAG_REGISTER) ? wbyte : 8'h00;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_flag_ff <= 8'h00;
    end else begin
      rx_flag_ff <= (rx_flag_ff & ~rf_clr) | rf_set;
    end
  end

  // power down wakeup can arrive with cpu stopped (ack may still be set)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_en_ff <= 8'h00;
      tx_en_ff <= 3'h0;
    end else if (bus_wr) begin
      if (adr_i == CILP_RX_IRQ_ENABLE) begin
        rx_en_ff <= wbyte;
      end
      if (adr_i == CILP_TX_IRQ_ENABLE) begin
        tx_en_ff <= wbyte[2:0];
      end
    end
  end

  // ------------------------------------------------------------
  // transmit empty flags: software clears to schedule
  // ------------------------------------------------------------
  logic [2:0] tf_clr;
  assign tf_clr = (bus_wr && adr_i == CILP_TX_FLAG_REGISTER) ? wbyte[2:0] : 3'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_empty_ff <= CILP_TX_EMPTY_RESET;
    end else begin
      tx_empty_ff <= (tx_empty_ff & ~tf_clr) | (engine_tx_done_i ? engine_tx_done_buf_i : 3'h0);
    end
  end

  // ------------------------------------------------------------
  // mode table and bus recovery after wake
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= CILP_MODE_SOFT_RESET;
    end else if (cpu_stop_i) begin
      mode_ff <= CILP_MODE_POWER_DOWN;
    end else begin
      unique case ({ctrl0_ff[CILP_MC0_SLEEP_ACK], ctrl0_ff[CILP_MC0_SOFT_RESET]})
        2'b10: mode_ff <= CILP_MODE_SLEEP;
        2'b01: mode_ff <= CILP_MODE_SOFT_RESET;
        2'b00: mode_ff <= CILP_MODE_NORMAL;
        default: mode_ff <= CILP_MODE_SOFT_RESET; // both set is treated as soft reset
      endcase
    end
  end

  // idle counter: recessive bits in a row, restarted in low power so wake-up waits afresh
  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_sync_ff || low_power) begin
      idle_cnt_ff <= 4'h0;
    end else if (engine_bit_tick_i && idle_cnt_ff != 4'(CILP_IDLE_BITS)) begin
      idle_cnt_ff <= idle_cnt_ff + 4'h1;
    end
  end

  // after leaving a low-power mode wait for an idle bus
  always_ff @(posedge clk_i) begin
    if (rst_i || low_power) begin
      resync_ff <= 1'b1;
    end else if (idle_cnt_ff == 4'(CILP_IDLE_BITS)) begin
      resync_ff <= 1'b0;
    end
  end

  // bus-off recovery: 128 runs of 11 recessive bits, frozen in sleep
  always_ff @(posedge clk_i) begin
    if (rst_i || !bus_off_now) begin
      recov_runs_ff <= 8'h00;
      recov_bits_ff <= 4'h0;
    end else if (mode_ff == CILP_MODE_NORMAL && engine_bit_tick_i &&
                 recov_runs_ff != 8'(CILP_RECOVERY_RUNS)) begin
      if (!rx_sync_ff) begin
        recov_bits_ff <= 4'h0;
      end else if (recov_bits_ff == 4'(CILP_IDLE_BITS - 1)) begin
        recov_bits_ff <= 4'h0;
        recov_runs_ff <= recov_runs_ff + 8'h01;
      end else begin
        recov_bits_ff <= recov_bits_ff + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // frame pulse for the timer link
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_ff <= 1'b0;
    end else if (engine_eof_ok_i) begin
      pulse_ff <= 1'b1;
    end else if (engine_bit_tick_i) begin
      pulse_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      can_transmit_pin_o <= 1'b1;
      engine_run_o <= 1'b0;
      engine_copy_en_o <= 1'b0;
      engine_abort_en_o <= 1'b0;
      engine_stop_o <= 1'b1;
      recovery_done_o <= 1'b0;
      tx_scheduled_o <= 3'h0;
      wakeup_irq_o <= 1'b0;
      error_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
      tx_irq_o <= 1'b0;
      timer_capture_o <= 1'b0;
      cpu_wake_o <= 1'b0;
    end else begin
      can_transmit_pin_o <= low_power ? 1'b1 : engine_tx_bit_i;
      engine_run_o <= !low_power && !resync_ff;
      engine_copy_en_o <= !low_power;
      engine_abort_en_o <= !low_power;
      // soft reset or power down stop the engine at once
      engine_stop_o <= cfg_unlocked || cpu_stop_i;
      recovery_done_o <= recov_runs_ff == 8'(CILP_RECOVERY_RUNS);
      tx_scheduled_o <= ~tx_empty_ff;
      wakeup_irq_o <= rx_flag_ff[CILP_RF_WAKEUP] && rx_en_ff[CILP_RF_WAKEUP];
      error_irq_o <= |(rx_flag_ff & rx_en_ff & CILP_RF_ERR_MASK);
      rx_irq_o <= rx_flag_ff[CILP_RF_RX_FULL] && rx_en_ff[CILP_RF_RX_FULL];
      tx_irq_o <= |(tx_empty_ff & tx_en_ff);
      timer_capture_o <= pulse_ff && ctrl0_ff[CILP_MC0_TIMER_LINK];
      cpu_wake_o <= cpu_stop_i && activity;
    end
  end

  // ------------------------------------------------------------
  // wishbone answer: one cycle after request
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (adr_i)
      CILP_MODULE_CONTROL_0: rd_byte = ctrl0_ff;
      CILP_MODULE_CONTROL_1: rd_byte = ctrl1_ff;
      CILP_BUS_TIMING_0: rd_byte = btr0_ff;
      CILP_BUS_TIMING_1: rd_byte = btr1_ff;
      CILP_RX_FLAG_REGISTER: rd_byte = rx_flag_ff;
      CILP_RX_IRQ_ENABLE: rd_byte = rx_en_ff;
      CILP_TX_FLAG_REGISTER: rd_byte = {5'h00, tx_empty_ff};
      CILP_TX_IRQ_ENABLE: rd_byte = {5'h00, tx_en_ff};
      CILP_ACCEPTANCE_CONTROL: rd_byte = idac_ff;
      CILP_STATUS: rd_byte = {6'h00, mode_ff};
      default: ;
    endcase
    for (int i = 0; i < FILTER_REGS; i++) begin
      if (adr_i == CILP_ACCEPTANCE_PATTERNS + 8'(4 * i)) rd_byte = pattern_ff[i];
      if (adr_i == CILP_ACCEPTANCE_MASKS + 8'(4 * i)) rd_byte = mask_ff[i];
    end
  end

  // error counters read only; writes fall through harmlessly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= bus_wr || bus_rd || (cyc_i && stb_i && we_i && !sel_i[0] && !ack_o && !cpu_stop_i);
      err_o <= 1'b0;
      if (bus_rd) begin
        dat_o <= (adr_i == CILP_ERROR_COUNTERS) ?
                 {7'h00, tx_err_count_i, 7'h00, rx_err_count_i} : {24'h000000, rd_byte};
      end
    end
  end
endmodule
`default_nettype wire

// File: test/cilp_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checks on the low-power and interrupt block
// ------------------------------------------------------------
module cilp_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic cpu_stop_i,
  input wire logic engine_eof_ok_i,
  input wire logic ack_o,
  input wire logic can_transmit_pin_o,
  input wire logic engine_stop_o,
  input wire logic engine_run_o,
  input wire logic engine_copy_en_o,
  input wire logic engine_abort_en_o,
  input wire logic [2:0] tx_scheduled_o,
  input wire logic tx_irq_o,
  input wire logic timer_capture_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // three cycles give the registered mode time to follow
  sequence stop_held;
    cpu_stop_i [*3];
  endsequence
  sequence engine_halted;
    engine_stop_o [*3];
  endsequence
  sequence none_empty;
    (tx_scheduled_o == 3'h7) [*2];
  endsequence
  bus_ack_a: assert property (cyc_i && stb_i && !ack_o && !cpu_stop_i |=> ack_o)
    else $error("no ack one cycle after request");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i) ##1 !ack_o)
    else $error("ack without request or longer than one cycle");
  stop_noack_a: assert property (cpu_stop_i && $past(cpu_stop_i) |-> !ack_o)
    else $error("ack while cpu stopped");
  pin_recess_a: assert property (engine_halted |-> can_transmit_pin_o && !engine_run_o)
    else $error("transmit pin or engine active while stopped");
  stop_engine_a: assert property (stop_held |-> engine_stop_o && !engine_copy_en_o && !engine_abort_en_o)
    else $error("engine not halted in power down");
  tx_irq_idle_a: assert property (none_empty |-> !tx_irq_o)
    else $error("transmit request with no empty buffer");
  frame_pulse_a: assert property ($rose(timer_capture_o) |-> $past(engine_eof_ok_i) || $past(engine_eof_ok_i, 2))
    else $error("timer pulse without frame end");
  pd_pin_a: assert property (stop_held |-> can_transmit_pin_o)
    else $error("transmit pin dominant in power down");
endmodule
bind cilp_can_irq_lowpower cilp_checker u_chk (.*);
`default_nettype wire

// File: test/cilp_can_node.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// remote node: sends dominant bursts, bus idles recessive
// ------------------------------------------------------------
module cilp_can_node (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic send_i,
  output logic pin_o
);
  logic [3:0] phase_ff;
  // phase restarts per burst so the wake filter always sees eight dominant cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || !send_i) begin
      phase_ff <= 4'h0;
    end else begin
      phase_ff <= phase_ff + 4'h1;
    end
  end
  // pull-up keeps the released line recessive
  assign pin_o = send_i ? phase_ff[3] : 1'b1;
endmodule
`default_nettype wire

// File: test/test_can_irq_lowpower_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_can_irq_lowpower_control;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, cpu_stop_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic engine_tx_bit_i = 1'b1, engine_tx_busy_i = 1'b0, engine_rx_busy_i = 1'b0;
  logic engine_eof_ok_i = 1'b0, engine_rx_stored_i = 1'b0, engine_overrun_i = 1'b0;
  logic engine_tx_done_i = 1'b0, engine_bit_tick_i = 1'b0, send = 1'b0;
  logic [2:0] engine_tx_done_buf_i = 3'h0;
  logic [8:0] rx_err_count_i = 9'h0, tx_err_count_i = 9'h0;
  logic [1:0] tick_cnt = 2'h0;
  wire logic can_receive_pin_i;
  logic [31:0] dat_o, rdata;
  logic ack_o, err_o, can_transmit_pin_o, engine_run_o, engine_copy_en_o, engine_abort_en_o;
  logic engine_stop_o, recovery_done_o, wakeup_irq_o, error_irq_o, rx_irq_o, tx_irq_o;
  logic timer_capture_o, cpu_wake_o, seen;
  logic [2:0] tx_scheduled_o;
  logic [7:0] locked [12] = '{8'h04, 8'h08, 8'h0C, 8'h20, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C};
  int mismatches = 0, total_checks = 0;

  cilp_can_irq_lowpower dut (.*);
  cilp_can_node u_node (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .pin_o(can_receive_pin_i));

  // ------------------------------------------------------------
  // clock and bit ticks
  // ------------------------------------------------------------
  always #2 clk_i = ~clk_i;
  // a bit every fourth cycle keeps recessive runs short
  always @(posedge clk_i) begin
    tick_cnt <= tick_cnt + 2'h1;
    engine_bit_tick_i <= (tick_cnt == 2'h3);
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task chk1(input logic s, input logic e);
    chk({31'h0, s}, {31'h0, e});
  endtask
  // classic single cycle; held until ack is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 64);
    if (n >= 64) begin
      mismatches++;
      report_and_stop();
    end
    rdata = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task done(input logic [2:0] b);
    @(posedge clk_i);
    engine_tx_done_i <= 1'b1;
    engine_tx_done_buf_i <= b;
    @(posedge clk_i);
    engine_tx_done_i <= 1'b0;
    engine_tx_done_buf_i <= 3'h0;
  endtask
  task burst;
    @(posedge clk_i);
    send <= 1'b1;
    wt(12);
    send <= 1'b0;
  endtask
  function automatic logic [7:0] pv(input logic [7:0] a);
    pv = (a == 8'h04) ? 8'h04 : a + 8'h11;
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    wt(12);
    rst_i <= 1'b0;
    rd(8'h00, 32'h1);
    rd(8'h18, 32'h7);
    rd(8'h50, 32'h2);
    // configuration open in soft reset, locked after
    for (int i = 0; i < 12; i++) wr(locked[i], pv(locked[i]));
    wr(8'h00, 8'h00);
    for (int i = 0; i < 12; i++) wr(locked[i], ~pv(locked[i]));
    for (int i = 0; i < 12; i++) rd(locked[i], {24'h0, pv(locked[i])});
    rd(8'h50, 32'h0);
    rd(8'h60, 32'h0);
    rx_err_count_i <= 9'h015;
    tx_err_count_i <= 9'h03C;
    bus(1'b1, 8'h24, 32'hFFFFFFFF);
    chk1(err_o, 1'b0);
    rd(8'h24, 32'h003C0015);
    // transmit empties and their request
    wr(8'h1C, 8'h07);
    wt(3);
    chk1(tx_irq_o, 1'b1);
    wr(8'h18, 8'h00);
    rd(8'h18, 32'h7);
    wr(8'h18, 8'h07);
    rd(8'h18, 32'h0);
    chk1(tx_irq_o, 1'b0);
    chk({29'h0, tx_scheduled_o}, 32'h7);
    done(3'h2);
    wt(3);
    rd(8'h18, 32'h2);
    chk1(tx_irq_o, 1'b1);
    done(3'h5);
    wt(3);
    rd(8'h18, 32'h7);
    // frame end: receive full and timer pulse
    wr(8'h00, 8'h08);
    wr(8'h14, 8'h7F);
    @(posedge clk_i);
    engine_eof_ok_i <= 1'b1;
    engine_rx_stored_i <= 1'b1;
    @(posedge clk_i);
    engine_eof_ok_i <= 1'b0;
    engine_rx_stored_i <= 1'b0;
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk_i);
      seen = seen | timer_capture_o;
    end
    chk1(seen, 1'b1);
    chk1(rx_irq_o, 1'b1);
    wt(4);
    chk1(timer_capture_o, 1'b0);
    wr(8'h10, 8'h00);
    rd(8'h10, 32'h1);
    wr(8'h10, 8'h01);
    rd(8'h10, 32'h0);
    // error counter thresholds, one below first
    rx_err_count_i <= 9'h05F;
    tx_err_count_i <= 9'h05F;
    wt(3);
    rd(8'h10, 32'h0);
    rx_err_count_i <= 9'h080;
    tx_err_count_i <= 9'h100;
    @(posedge clk_i);
    engine_overrun_i <= 1'b1;
    @(posedge clk_i);
    engine_overrun_i <= 1'b0;
    wt(3);
    rd(8'h10, 32'h7E);
    chk1(error_irq_o, 1'b1);
    // bus-off recovery freezes in sleep; rejoin waits for idle bits
    wt(2000);
    chk1(recovery_done_o, 1'b0);
    wr(8'h00, 8'h0C);
    wt(6000);
    rd(8'h00, 32'hE);
    chk1(recovery_done_o, 1'b0);
    wr(8'h00, 8'h08);
    wt(8);
    chk1(engine_run_o, 1'b0);
    wt(4500);
    chk1(recovery_done_o, 1'b1);
    chk1(engine_run_o, 1'b1);
    wr(8'h10, 8'h7E);
    rd(8'h10, 32'h7C);
    rx_err_count_i <= 9'h000;
    tx_err_count_i <= 9'h000;
    wt(2);
    wr(8'h10, 8'h7E);
    rd(8'h10, 32'h0);
    chk1(error_irq_o, 1'b0);
    // sleep entry, wake by activity
    engine_tx_bit_i <= 1'b0;
    wr(8'h14, 8'h80);
    burst();
    wt(4);
    chk1(wakeup_irq_o, 1'b0);
    chk1(can_transmit_pin_o, 1'b0);
    engine_tx_busy_i <= 1'b1;
    wr(8'h00, 8'h04);
    rd(8'h00, 32'h4);
    wr(8'h00, 8'h00);
    rd(8'h00, 32'h4);
    engine_tx_busy_i <= 1'b0;
    wt(4);
    rd(8'h00, 32'h6);
    rd(8'h50, 32'h1);
    chk1(can_transmit_pin_o, 1'b1);
    chk1(engine_copy_en_o, 1'b0);
    burst();
    wt(4);
    chk1(wakeup_irq_o, 1'b1);
    rd(8'h00, 32'h0);
    wr(8'h10, 8'h80);
    rd(8'h10, 32'h0);
    // wake by clearing request, then by soft reset
    wr(8'h00, 8'h04);
    wt(4);
    rd(8'h00, 32'h6);
    wr(8'h00, 8'h00);
    rd(8'h00, 32'h0);
    wr(8'h00, 8'h04);
    wt(4);
    wr(8'h00, 8'h01);
    rd(8'h00, 32'h1);
    chk1(engine_stop_o, 1'b1);
    // power down: bus refused, activity still wakes the cpu
    cpu_stop_i <= 1'b1;
    wt(3);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= 1'b0;
    adr_i <= 8'h00;
    seen = 1'b0;
    repeat (6) begin
      @(posedge clk_i);
      seen = seen | ack_o;
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    chk1(seen, 1'b0);
    chk1(can_transmit_pin_o, 1'b1);
    // wake indication is a one-cycle pulse, so watch through the burst
    seen = 1'b0;
    @(posedge clk_i);
    send <= 1'b1;
    repeat (12) begin
      @(posedge clk_i);
      seen = seen | cpu_wake_o;
    end
    send <= 1'b0;
    chk1(seen, 1'b1);
    cpu_stop_i <= 1'b0;
    wt(3);
    rd(8'h50, 32'h2);
    report_and_stop();
  end
endmodule
`default_nettype wire
